// [servo_stop_and_resonance_ctrl.sv]
// Behaviour
// (R1) Stop on alarm or limit while enabled.
// (R2) Stop enable accepts 0/1, default 0.
// (R3) Select 0: limits block own direction.
// (R4) Select 2: either single limit raises overtravel.
// (R5) Master triggers stop via quick-stop object.
// (R6) Braking setting zero uses normal limit.
// (R7) Nonzero braking uses min with max torque.
// (R8) Torque filter constant in 0.01 ms units.
// (R9) Notch width spans the -3 dB points.
// (R10) Depth 0 blocks centre; larger attenuates less.
// (R11) Auto select 1 updates third notch group.
// (R12) Auto select 0 stops third-group updates.
// (R13) Two low-frequency suppression frequencies stored.
`timescale 1ns/1ps
`default_nettype none
`include "servo_stop_defines.svh"

module servo_stop_and_resonance_ctrl
  import servo_stop_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire param_req_t  paramReq,
  output var  logic [15:0] paramRdata,
  output var  logic        paramAck,
  input  wire logic        driveEnabled,
  input  wire logic        alarmActive,
  input  wire logic        homingMode,
  input  wire logic        positive_limit_input,
  input  wire logic        negative_limit_input,
  output var  logic        emergencyStop,
  output var  logic        overtravel_error,
  output var  logic        posMotionBlock,
  output var  logic        negMotionBlock,
  output var  logic [15:0] torqueLimit,
  output var  logic [15:0] torque_filter_constant,
  output var  notch_set_t  notchThree,
  output var  logic [15:0] low_freq_suppress_one,
  output var  logic [15:0] low_freq_suppress_two
);

  // Parameter storage.
  logic [15:0] estopEn_r,   estopEn_nxt;
  logic [15:0] travelSel_r, travelSel_nxt;
  logic [15:0] brakeTq_r,   brakeTq_nxt;
  logic [15:0] maxTq_r,     maxTq_nxt;
  logic [15:0] autoSel_r,   autoSel_nxt;
  logic [15:0] stiff_r,     stiff_nxt;
  logic [15:0] filt_r,      filt_nxt;
  logic [15:0] lf1_r,       lf1_nxt;
  logic [15:0] lf2_r,       lf2_nxt;
  logic        quick_r,     quick_nxt;
  notch_set_t  notch_r,     notch_nxt;
  logic [15:0] rdata_r,     rdata_nxt;
  logic        ack_r,       ack_nxt;
  logic        autoValid;
  notch_set_t  autoSet;
  logic        wr;

  assign wr = paramReq.wrEn;

  notch_auto_tuner u_tuner (
    .core_clk    (core_clk),
    .rst         (rst),
    .stiffness   (stiff_r),
    .enable      ((autoSel_r == 16'h0001) && driveEnabled), // [R11] [R12]
    .updateValid (autoValid),
    .updateSet   (autoSet)
  );

  always_comb begin
    estopEn_nxt   = estopEn_r;
    travelSel_nxt = travelSel_r;
    brakeTq_nxt   = brakeTq_r;
    maxTq_nxt     = maxTq_r;
    autoSel_nxt   = autoSel_r;
    stiff_nxt     = stiff_r;
    filt_nxt      = filt_r;
    lf1_nxt       = lf1_r;
    lf2_nxt       = lf2_r;
    quick_nxt     = quick_r;
    notch_nxt     = notch_r;
    // Out-of-range writes to stop enable, travel select, braking torque and notch depth are dropped; other settings take any code.
    if (wr) begin
      case (paramReq.addr)
        `ADDR_ESTOP_ENABLE: begin
          if (paramReq.wdata <= `MAX_ESTOP_ENABLE)
            estopEn_nxt = paramReq.wdata; // [R2]
        end
        `ADDR_TRAVEL_SELECT: begin
          if (paramReq.wdata <= `MAX_TRAVEL_SELECT)
            travelSel_nxt = paramReq.wdata;
        end
        `ADDR_BRAKE_TORQUE: begin
          if (paramReq.wdata <= `MAX_BRAKE_TORQUE)
            brakeTq_nxt = paramReq.wdata;
        end
        `ADDR_MAX_TORQUE:    maxTq_nxt = paramReq.wdata;
        `ADDR_AUTO_NOTCH:    autoSel_nxt = paramReq.wdata;
        `ADDR_STIFFNESS:     stiff_nxt = paramReq.wdata;
        `ADDR_TORQUE_FILTER: filt_nxt = paramReq.wdata; // [R8]
        `ADDR_LOWFREQ_ONE:   lf1_nxt = paramReq.wdata; // [R13]
        `ADDR_LOWFREQ_TWO:   lf2_nxt = paramReq.wdata; // [R13]
        `ADDR_QUICK_STOP:    quick_nxt = (paramReq.wdata != 16'h0000); // [R5]
        `ADDR_NOTCH3_FREQ:   notch_nxt.freq = paramReq.wdata;
        `ADDR_NOTCH3_WIDTH:  notch_nxt.width = paramReq.wdata; // [R9]
        `ADDR_NOTCH3_DEPTH: begin
          if (paramReq.wdata <= `MAX_NOTCH_DEPTH)
            notch_nxt.depth = paramReq.wdata; // [R10]
        end
        default: ;
      endcase
    end
    // The tuner wins over a software write in the same cycle.
    if (autoValid && (autoSel_r == 16'h0001))
      notch_nxt = autoSet; // [R11] [R12]
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    ack_nxt   = paramReq.rdEn || paramReq.wrEn;
    case (paramReq.addr)
      `ADDR_ESTOP_ENABLE:  rdata_nxt = estopEn_r;
      `ADDR_TRAVEL_SELECT: rdata_nxt = travelSel_r;
      `ADDR_BRAKE_TORQUE:  rdata_nxt = brakeTq_r;
      `ADDR_MAX_TORQUE:    rdata_nxt = maxTq_r;
      `ADDR_AUTO_NOTCH:    rdata_nxt = autoSel_r;
      `ADDR_STIFFNESS:     rdata_nxt = stiff_r;
      `ADDR_TORQUE_FILTER: rdata_nxt = filt_r;
      `ADDR_LOWFREQ_ONE:   rdata_nxt = lf1_r;
      `ADDR_LOWFREQ_TWO:   rdata_nxt = lf2_r;
      `ADDR_QUICK_STOP:    rdata_nxt = {15'h0000, quick_r};
      `ADDR_NOTCH3_FREQ:   rdata_nxt = notch_r.freq;
      `ADDR_NOTCH3_WIDTH:  rdata_nxt = notch_r.width;
      `ADDR_NOTCH3_DEPTH:  rdata_nxt = notch_r.depth;
      `ADDR_STATUS: begin
        rdata_nxt[`ST_ESTOP_BIT]      = emergencyStop;
        rdata_nxt[`ST_OVERTRAVEL_BIT] = overtravel_error;
        rdata_nxt[`ST_POS_BLOCK_BIT]  = posMotionBlock;
        rdata_nxt[`ST_NEG_BLOCK_BIT]  = negMotionBlock;
      end
      default: rdata_nxt = 16'h0000;
    endcase
    if (!paramReq.rdEn)
      rdata_nxt = 16'h0000;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      estopEn_r   <= `RST_ESTOP_ENABLE;
      travelSel_r <= `RST_TRAVEL_SELECT;
      brakeTq_r   <= `RST_BRAKE_TORQUE;
      maxTq_r     <= `RST_MAX_TORQUE;
      autoSel_r   <= 16'h0000;
      stiff_r     <= 16'h0000;
      filt_r      <= 16'h0000;
      lf1_r       <= 16'h0000;
      lf2_r       <= 16'h0000;
      quick_r     <= 1'b0;
      notch_r     <= '0;
      rdata_r     <= 16'h0000;
      ack_r       <= 1'b0;
    end else begin
      estopEn_r   <= estopEn_nxt;
      travelSel_r <= travelSel_nxt;
      brakeTq_r   <= brakeTq_nxt;
      maxTq_r     <= maxTq_nxt;
      autoSel_r   <= autoSel_nxt;
      stiff_r     <= stiff_nxt;
      filt_r      <= filt_nxt;
      lf1_r       <= lf1_nxt;
      lf2_r       <= lf2_nxt;
      quick_r     <= quick_nxt;
      notch_r     <= notch_nxt;
      rdata_r     <= rdata_nxt;
      ack_r       <= ack_nxt;
    end
  end

  // Stop and limit logic.
  logic        estop_r,  estop_nxt;
  logic        otErr_r,  otErr_nxt;
  logic        posBlk_r, posBlk_nxt;
  logic        negBlk_r, negBlk_nxt;
  logic [15:0] tqLim_r,  tqLim_nxt;
  logic        limitHit;

  always_comb begin
    posBlk_nxt = 1'b0;
    negBlk_nxt = 1'b0;
    otErr_nxt  = otErr_r;
    limitHit   = 1'b0;
    if (!homingMode) begin
      case (travelSel_r)
        `TRAVEL_BLOCK: begin
          posBlk_nxt = positive_limit_input; // [R3]
          negBlk_nxt = negative_limit_input; // [R3]
          limitHit   = positive_limit_input || negative_limit_input;
        end
        `TRAVEL_ERROR: begin
          // Error is sticky until the select leaves code 2.
          if (positive_limit_input ^ negative_limit_input)
            otErr_nxt = 1'b1; // [R4]
          limitHit = positive_limit_input || negative_limit_input;
        end
        default: ;
      endcase
    end
    if (travelSel_r != `TRAVEL_ERROR)
      otErr_nxt = 1'b0;
    // Writing the enable changes emergencyStop two cycles later, with no latching.
    estop_nxt = quick_r ||
                ((estopEn_r == 16'h0001) &&
                 (alarmActive || otErr_r ||
                  (limitHit && driveEnabled))); // [R1] [R2] [R5]
    if (brakeTq_r == 16'h0000)
      tqLim_nxt = maxTq_r; // [R6]
    else if (estop_r)
      tqLim_nxt = (brakeTq_r < maxTq_r) ? brakeTq_r : maxTq_r; // [R7]
    else
      tqLim_nxt = maxTq_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      estop_r  <= 1'b0;
      otErr_r  <= 1'b0;
      posBlk_r <= 1'b0;
      negBlk_r <= 1'b0;
      tqLim_r  <= `RST_MAX_TORQUE;
    end else begin
      estop_r  <= estop_nxt;
      otErr_r  <= otErr_nxt;
      posBlk_r <= posBlk_nxt;
      negBlk_r <= negBlk_nxt;
      tqLim_r  <= tqLim_nxt;
    end
  end

  assign paramRdata             = rdata_r;
  assign paramAck               = ack_r;
  assign emergencyStop          = estop_r;
  assign overtravel_error       = otErr_r;
  assign posMotionBlock         = posBlk_r;
  assign negMotionBlock         = negBlk_r;
  assign torqueLimit            = tqLim_r;
  assign torque_filter_constant = filt_r;
  assign notchThree             = notch_r;
  assign low_freq_suppress_one  = lf1_r;
  assign low_freq_suppress_two  = lf2_r;

endmodule // servo_stop_and_resonance_ctrl

`default_nettype wire

// [servo_stop_defines.svh]
`ifndef SERVO_STOP_DEFINES_SVH
`define SERVO_STOP_DEFINES_SVH

// Parameter addresses on the parameter port.
`define ADDR_ESTOP_ENABLE      16'h2443
`define ADDR_TRAVEL_SELECT     16'h2504
`define ADDR_BRAKE_TORQUE      16'h2511
`define ADDR_AUTO_NOTCH        16'h2200
`define ADDR_NOTCH3_FREQ       16'h2207
`define ADDR_NOTCH3_WIDTH      16'h2208
`define ADDR_NOTCH3_DEPTH      16'h2209
`define ADDR_LOWFREQ_ONE       16'h2214
`define ADDR_LOWFREQ_TWO       16'h2216
`define ADDR_TORQUE_FILTER     16'h2104
`define ADDR_STIFFNESS         16'h2003
`define ADDR_MAX_TORQUE        16'h6072
`define ADDR_QUICK_STOP        16'h605A
`define ADDR_STATUS            16'h2600

// Reset values.
`define RST_ESTOP_ENABLE       16'h0000
`define RST_TRAVEL_SELECT      16'h0000
`define RST_BRAKE_TORQUE       16'h0000
`define RST_MAX_TORQUE         16'h01F4
`define RST_NOTCH_DEPTH        16'h0000

// Value limits.
`define MAX_ESTOP_ENABLE       16'h0001
`define MAX_TRAVEL_SELECT      16'h0002
`define MAX_BRAKE_TORQUE       16'h01F4
`define MAX_NOTCH_DEPTH        16'h0064

// Travel select codes.
`define TRAVEL_BLOCK           16'h0000
`define TRAVEL_IGNORE          16'h0001
`define TRAVEL_ERROR           16'h0002

// Status field positions.
`define ST_ESTOP_BIT           0
`define ST_OVERTRAVEL_BIT      1
`define ST_POS_BLOCK_BIT       2
`define ST_NEG_BLOCK_BIT       3

`endif

// [servo_stop_pkg.sv]
package servo_stop_pkg;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [15:0] addr;
    logic [15:0] wdata;
  } param_req_t;

  typedef struct packed {
    logic [15:0] freq;
    logic [15:0] width;
    logic [15:0] depth;
  } notch_set_t;

  typedef enum logic [1:0] {
    STOP_IDLE,
    STOP_ACTIVE,
    STOP_HOLD
  } stop_state_t;

endpackage

// [notch_auto_tuner.sv]
`timescale 1ns/1ps
`default_nettype none

// Derives the third notch group from the stiffness level. The mapping is a
// plain linear estimate; a real tuner would measure the resonance instead.
module notch_auto_tuner
  import servo_stop_pkg::*;
#(
  parameter logic [15:0] BASE_FREQ = 16'h0FA0,
  parameter logic [15:0] FREQ_STEP = 16'h0064,
  parameter logic [15:0] WIDTH_VAL = 16'h0002,
  parameter logic [15:0] DEPTH_VAL = 16'h0000
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [15:0] stiffness,
  input  wire logic       enable,
  output var  logic       updateValid,
  output var  notch_set_t updateSet
);

  logic [15:0] lastStiff_r;
  logic [15:0] lastStiff_nxt;
  logic        valid_r;
  logic        valid_nxt;
  notch_set_t  set_r;
  notch_set_t  set_nxt;
  logic [31:0] prod;

  always_comb begin
    prod          = stiffness * FREQ_STEP;
    lastStiff_nxt = stiffness;
    valid_nxt     = 1'b0;
    set_nxt       = set_r;
    if (enable && (stiffness > lastStiff_r)) begin
      valid_nxt     = 1'b1;
      set_nxt.freq  = BASE_FREQ - prod[15:0];
      set_nxt.width = WIDTH_VAL;
      set_nxt.depth = DEPTH_VAL;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lastStiff_r <= 16'h0000;
      valid_r     <= 1'b0;
      set_r       <= '0;
    end else begin
      lastStiff_r <= lastStiff_nxt;
      valid_r     <= valid_nxt;
      set_r       <= set_nxt;
    end
  end

  assign updateValid = valid_r;
  assign updateSet   = set_r;

endmodule // notch_auto_tuner

`default_nettype wire

// [servo_stop_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "servo_stop_defines.svh"
module servo_stop_monitor
  import servo_stop_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire param_req_t  paramReq,
  input wire logic        paramAck,
  input wire logic        alarmActive,
  input wire logic        homingMode,
  input wire logic        positive_limit_input,
  input wire logic        negative_limit_input,
  input wire logic        emergencyStop,
  input wire logic        overtravel_error,
  input wire logic        posMotionBlock,
  input wire logic [15:0] torqueLimit,
  input wire notch_set_t  notchThree
);
  logic [15:0] en_r, qs_r, sel_r, brk_r, mt_r, auto_r, wd, lim;
  logic        wr;
  assign wd = paramReq.wdata;
  assign wr = paramReq.wrEn;
  assign lim = (brk_r == 16'h0000 || mt_r < brk_r) ? mt_r : brk_r;
  // Shadows refuse the same out-of-range writes as the device does.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {en_r, qs_r, sel_r, brk_r, auto_r} <= '0;
      mt_r <= `RST_MAX_TORQUE;
    end else if (wr) begin
      case (paramReq.addr)
        `ADDR_ESTOP_ENABLE: if (wd <= 16'h0001) en_r <= wd;
        `ADDR_TRAVEL_SELECT: if (wd <= 16'h0002) sel_r <= wd;
        `ADDR_BRAKE_TORQUE: if (wd <= 16'h01F4) brk_r <= wd;
        `ADDR_MAX_TORQUE: mt_r <= wd;
        `ADDR_QUICK_STOP: qs_r <= wd;
        `ADDR_AUTO_NOTCH: auto_r <= wd;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_ACK: assert property (
    (wr || paramReq.rdEn) |=> paramAck) else $error("No ack.");
  AST_QSTOP: assert property (
    wr && paramReq.addr == `ADDR_QUICK_STOP && wd != 16'h0000
    |-> ##2 emergencyStop) else $error("Quick stop ignored.");
  AST_ALARM: assert property (
    (en_r == 16'h0001 && alarmActive) [*3] |-> emergencyStop)
    else $error("Alarm did not stop.");
  AST_NO_CAUSE: assert property (
    emergencyStop |-> (en_r | qs_r | $past(en_r, 2) | $past(qs_r, 2))
    != 16'h0000) else $error("Stop while disabled.");
  AST_POS: assert property (
    (sel_r == 16'h0000 && positive_limit_input && !homingMode) [*3]
    |-> posMotionBlock) else $error("Positive side not blocked.");
  AST_OVT: assert property (
    (sel_r == 16'h0002 && !homingMode &&
     (positive_limit_input ^ negative_limit_input)) [*3]
    |-> overtravel_error) else $error("Overtravel not raised.");
  AST_TORQ: assert property (
    (!wr && $stable(emergencyStop)) [*4]
    |-> torqueLimit == (emergencyStop ? lim : mt_r))
    else $error("Torque limit wrong.");
  AST_AUTO_OFF: assert property (
    auto_r == 16'h0000 && !wr && !$past(wr) |=> $stable(notchThree))
    else $error("Notch group changed with auto off.");
endmodule // servo_stop_monitor
bind servo_stop_and_resonance_ctrl servo_stop_monitor mon_u (
  .core_clk(core_clk), .rst(rst), .paramReq(paramReq),
  .paramAck(paramAck), .alarmActive(alarmActive),
  .homingMode(homingMode), .positive_limit_input(positive_limit_input),
  .negative_limit_input(negative_limit_input),
  .emergencyStop(emergencyStop), .overtravel_error(overtravel_error),
  .posMotionBlock(posMotionBlock), .torqueLimit(torqueLimit),
  .notchThree(notchThree));
`default_nettype wire

// [servo_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module servo_master_model
  import servo_stop_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [15:0] paramRdata,
  input  wire logic        paramAck,
  output var  param_req_t  paramReq,
  output var  logic        positive_limit_input,
  output var  logic        negative_limit_input
);
  initial begin
    paramReq = '0;
    positive_limit_input = 1'b0;
    negative_limit_input = 1'b0;
  end
  // A strobe is taken at every edge it is seen, so it stands one edge only.
  task automatic access(input logic w, input logic [15:0] a, d,
                        output logic [15:0] q);
    @(posedge core_clk);
    paramReq <= '{wrEn: w, rdEn: !w, addr: a, wdata: d};
    @(posedge core_clk);
    paramReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    repeat (4) begin
      @(posedge core_clk);
      if (paramAck === 1'b1) break;
    end
    q = paramRdata;
  endtask
  task automatic limits(input logic p, n);
    @(posedge core_clk);
    positive_limit_input <= p;
    negative_limit_input <= n;
  endtask
endmodule // servo_master_model
`default_nettype wire

// [servo_stop_and_resonance_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "servo_stop_defines.svh"
module servo_stop_and_resonance_ctrl_tb import servo_stop_pkg::*;;
  logic        core_clk, rst, driveEnabled, alarmActive, homingMode;
  logic        posLim, negLim, paramAck, emergencyStop, overtravel, posBlk;
  logic        negBlk;
  logic [15:0] paramRdata, torqueLimit, filt, lf1, lf2, q, v;
  param_req_t  paramReq;
  notch_set_t  notchThree;
  int          errCount = 0;
  int          nCompared = 0;
  servo_stop_and_resonance_ctrl dut_u (
    .core_clk(core_clk), .rst(rst), .paramReq(paramReq),
    .paramRdata(paramRdata), .paramAck(paramAck),
    .driveEnabled(driveEnabled), .alarmActive(alarmActive),
    .homingMode(homingMode), .positive_limit_input(posLim),
    .negative_limit_input(negLim), .emergencyStop(emergencyStop),
    .overtravel_error(overtravel), .posMotionBlock(posBlk),
    .negMotionBlock(negBlk), .torqueLimit(torqueLimit),
    .torque_filter_constant(filt), .notchThree(notchThree),
    .low_freq_suppress_one(lf1), .low_freq_suppress_two(lf2));
  servo_master_model mst_u (
    .core_clk(core_clk), .paramRdata(paramRdata), .paramAck(paramAck),
    .paramReq(paramReq), .positive_limit_input(posLim),
    .negative_limit_input(negLim));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    mst_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a);
    mst_u.access(1'b0, a, 16'h0000, v);
  endtask
  task automatic pause;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic restart;
    rst <= 1'b1;
    driveEnabled <= 1'b0;
    alarmActive <= 1'b0;
    mst_u.limits(1'b0, 1'b0);
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
  endtask
  task automatic tNotch;
    wr(`ADDR_TORQUE_FILTER, 16'h0064);
    wr(`ADDR_LOWFREQ_ONE, 16'h0032);
    wr(`ADDR_LOWFREQ_TWO, 16'h0046);
    pause();
    chk("filter", 16'h0064, filt);
    chk("lowOne", 16'h0032, lf1);
    chk("lowTwo", 16'h0046, lf2);
    wr(`ADDR_NOTCH3_DEPTH, 16'h0065);
    rd(`ADDR_NOTCH3_DEPTH);
    chk("depth", `RST_NOTCH_DEPTH, v);
    wr(`ADDR_NOTCH3_WIDTH, 16'h0010);
    wr(`ADDR_NOTCH3_DEPTH, `MAX_NOTCH_DEPTH);
    pause();
    chk("width", 16'h0010, notchThree.width);
    chk("depthMax", `MAX_NOTCH_DEPTH, notchThree.depth);
    driveEnabled <= 1'b1;
    wr(`ADDR_AUTO_NOTCH, 16'h0001);
    wr(`ADDR_STIFFNESS, 16'h0005);
    pause();
    chk("autoFreq", 16'h0FA0 - 16'h01F4, notchThree.freq);
    chk("autoWidth", 16'h0002, notchThree.width);
    wr(`ADDR_AUTO_NOTCH, 16'h0000);
    wr(`ADDR_STIFFNESS, 16'h0009);
    pause();
    chk("autoOff", 16'h0FA0 - 16'h01F4, notchThree.freq);
    $display("done notch");
  endtask
  task automatic tBrake;
    wr(`ADDR_QUICK_STOP, 16'h0001);
    pause();
    chk("quickStop", 16'h0001, emergencyStop);
    chk("brakeZero", `RST_MAX_TORQUE, torqueLimit);
    wr(`ADDR_BRAKE_TORQUE, 16'h0064);
    pause();
    chk("brakeMin", 16'h0064, torqueLimit);
    wr(`ADDR_MAX_TORQUE, 16'h0032);
    wr(`ADDR_BRAKE_TORQUE, 16'h01F5);
    pause();
    chk("maxMin", 16'h0032, torqueLimit);
    rd(`ADDR_BRAKE_TORQUE);
    chk("brakeRange", 16'h0064, v);
    wr(`ADDR_QUICK_STOP, 16'h0000);
    pause();
    chk("brakeOff", 16'h0032, torqueLimit);
    $display("done brake");
  endtask
  task automatic tStop;
    alarmActive <= 1'b1;
    rd(`ADDR_ESTOP_ENABLE);
    chk("enReset", `RST_ESTOP_ENABLE, v);
    chk("stopOff", 16'h0000, emergencyStop);
    wr(`ADDR_ESTOP_ENABLE, 16'h0002);
    rd(16'h1234);
    chk("unmapped", 16'h0000, v);
    rd(`ADDR_ESTOP_ENABLE);
    chk("enRange", 16'h0000, v);
    wr(`ADDR_ESTOP_ENABLE, 16'h0001);
    pause();
    chk("alarmStop", 16'h0001, emergencyStop);
    rd(`ADDR_STATUS);
    chk("statusStop", 16'h0001, v & 16'h0001);
    $display("done stop");
  endtask
  task automatic tLimits;
    driveEnabled <= 1'b1;
    wr(`ADDR_ESTOP_ENABLE, 16'h0001);
    mst_u.limits(1'b1, 1'b0);
    pause();
    chk("posBlock", 16'h0001, posBlk);
    chk("negFree", 16'h0000, negBlk);
    chk("limitStop", 16'h0001, emergencyStop);
    mst_u.limits(1'b0, 1'b1);
    pause();
    chk("negBlock", 16'h0001, negBlk);
    wr(`ADDR_TRAVEL_SELECT, `TRAVEL_ERROR);
    pause();
    chk("overtravel", 16'h0001, overtravel);
    wr(`ADDR_TRAVEL_SELECT, `TRAVEL_IGNORE);
    pause();
    chk("otClear", 16'h0000, overtravel);
    // Homing mode must mask the limit that is still active.
    homingMode <= 1'b1;
    wr(`ADDR_TRAVEL_SELECT, `TRAVEL_BLOCK);
    pause();
    chk("homingFree", 16'h0000, negBlk);
    chk("homingStop", 16'h0000, emergencyStop);
    homingMode <= 1'b0;
    pause();
    chk("homingOff", 16'h0001, negBlk);
    $display("done limits");
  endtask
  task automatic completeRun;
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    driveEnabled = 1'b0;
    alarmActive = 1'b0;
    homingMode = 1'b0;
    restart();
    tNotch();
    tBrake();
    restart();
    tStop();
    restart();
    tLimits();
    completeRun();
  end
  // The tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    completeRun();
  end
endmodule // servo_stop_and_resonance_ctrl_tb
`default_nettype wire
